// ==== inc/tsr_consts.vh ====
// Constants for the temperature result and shutdown control block.
// Assumes a 40 MHz system clock and a 2-wire framing layer outside.
// Notes on behaviour
// - Resolution 9 to 12 bits, 0.5 to 0.0625 steps
// - Resolution code zero selects 9 bits default
// - Conversion time doubles per extra resolution bit
// - Each conversion stores 16-bit two's complement result
// - Bit 15 sign, bits 14..4 weigh 2^6..2^-4
// - Result bits 3..0 always read zero
// - Unused low bits per resolution forced zero
// - Result readable anytime, read never disturbs conversion
// - 12-bit encoding matches example table values
// - Shutdown finishes running conversion, stores, then standby
// - Shutdown entry clears alarm only in interrupt mode
// - Interface works in shutdown; clearing shutdown resumes
// - Shutdown at power-up: one conversion, then standby
// - Power-up mode chosen by stored shutdown setting
// - Own SDA low 75-325 ms resets interface, releases
// - Others holding SDA low never trigger reset
// - SDA only pulled low or released; SCL sampled
// - Interrupt mode alarm cleared by register read
// - Resolution bits 6,5, shutdown bit 0, restored
`ifndef TSR_CONSTS_VH
`define TSR_CONSTS_VH

// Register pointers
`define TSR_PTR_W 2
`define TSR_PTR_TEMP 2'h0
`define TSR_PTR_CFG 2'h1
`define TSR_PTR_TOS 2'h2
`define TSR_PTR_HYST 2'h3

// Configuration byte fields
`define TSR_CFG_RES_HI 6
`define TSR_CFG_RES_LO 5
`define TSR_CFG_TM 1
`define TSR_CFG_SD 0
`define TSR_CFG_WMASK 8'h7f
`define TSR_CFG_RST 8'h00

// Resolution codes
`define TSR_RES_9B 2'h0
`define TSR_RES_10B 2'h1
`define TSR_RES_11B 2'h2
`define TSR_RES_12B 2'h3

// Result masks per resolution
`define TSR_MASK_9B 16'hff80
`define TSR_MASK_10B 16'hffc0
`define TSR_MASK_11B 16'hffe0
`define TSR_MASK_12B 16'hfff0

// Trip point storage and reset values
`define TSR_TRIP_MASK 16'hfff0
`define TSR_TOS_RST 16'h5000
`define TSR_HYST_RST 16'h4b00
`define TSR_WORD_RST 16'h0000

// Timing
`define TSR_CLK_KHZ 40000
`define TSR_CONV_9B_MS 25
`define TSR_LOCKUP_MIN_MS 75
`define TSR_LOCKUP_MAX_MS 325
`define TSR_CNT_W 24

`endif

// ==== logic/tsr_lockup.v ====
// Bus lockup watchdog for the open-drain data line.
// Assumes sda_level is already synchronised to sys_clk.
`timescale 1ns/1ps
`include "tsr_consts.vh"
module tsr_lockup #(
    parameter LIMIT_CYC = `TSR_LOCKUP_MIN_MS * `TSR_CLK_KHZ,
    parameter CNT_W = `TSR_CNT_W
) (
    input wire sys_clk,
    input wire rst_b,
    input wire sda_level,
    input wire own_drive,
    output reg timeout_ff
);
    reg [CNT_W-1:0] low_cnt_ff; // Cycles our own pull held the line low
    reg [CNT_W-1:0] nxt_low_cnt;
    reg nxt_timeout;
    wire own_low; // Low only counts while we are the one pulling

    assign own_low = own_drive & ~sda_level;

    // Next-state for the watchdog count
    always @*
    begin
        nxt_low_cnt = low_cnt_ff;
        nxt_timeout = 1'b0;
        if (!own_low)
        begin
            // Released or someone else: start over
            nxt_low_cnt = {CNT_W{1'b0}};
        end
        else if (low_cnt_ff == LIMIT_CYC[CNT_W-1:0] - 1'b1)
        begin
            // Limit reached: one pulse, then count again
            nxt_timeout = 1'b1;
            nxt_low_cnt = {CNT_W{1'b0}};
        end
        else
        begin
            nxt_low_cnt = low_cnt_ff + 1'b1;
        end
    end

    // Watchdog registers
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            low_cnt_ff <= {CNT_W{1'b0}};
            timeout_ff <= 1'b0;
        end
        else
        begin
            low_cnt_ff <= nxt_low_cnt;
            timeout_ff <= nxt_timeout;
        end
    end
endmodule

// ==== logic/tsr_top.v ====
// Result register, conversion sequencer, shutdown control, alarm
// clearing and line lockup release for the temperature sensor.
// Assumes a framing layer on sys_clk that decodes the 2-wire bus
// into register strobes, and an analog front end on sys_clk.
`timescale 1ns/1ps
`include "tsr_consts.vh"
module tsr_top #(
    parameter CONV_BASE_CYC = `TSR_CONV_9B_MS * `TSR_CLK_KHZ,
    parameter LOCKUP_CYC = `TSR_LOCKUP_MIN_MS * `TSR_CLK_KHZ,
    parameter CNT_W = `TSR_CNT_W
) (
    input wire sys_clk,
    input wire rst_b,
    // 2-wire pins
    input wire scl_pin,
    input wire sda_in,
    output reg sda_out_ff,
    output reg sda_oe_ff,
    // Framing layer side
    input wire sda_pull_req,
    output reg scl_level_ff,
    output reg sda_level_ff,
    output reg scl_rise_ff,
    output reg scl_fall_ff,
    output reg serial_reset_ff,
    // Register access from the framing layer
    input wire reg_rd_stb,
    input wire reg_wr_stb,
    input wire [`TSR_PTR_W-1:0] reg_ptr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata_ff,
    output reg reg_rvalid_ff,
    // Stored configuration image restored at power-up
    input wire [7:0] nv_config,
    // Analog front end
    input wire [15:0] adc_temp,
    output reg conv_active_ff,
    output reg result_stb_ff,
    output reg [15:0] temperature_result_ff,
    // Thermostat comparison outside
    input wire thermo_set,
    input wire thermo_clr,
    output reg [15:0] overtemp_trip_point_ff,
    output reg [15:0] lower_trip_point_ff,
    output reg [1:0] resolution_ff,
    output reg alarm_active_ff,
    output reg standby_ff
);
    // Sequencer states
    localparam ST_BOOT = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_STANDBY = 2'h2;

    // Pin synchronisers, first stage read only by the second
    reg scl_meta_ff;
    reg sda_meta_ff;
    reg scl_prev_ff; // Previous synced level for edges

    // Configuration and sequencer
    reg [7:0] cfg_ff; // Bit 7 reads zero, no NV write logic here
    reg [7:0] nxt_cfg;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [CNT_W-1:0] conv_cnt_ff; // Down counter for one conversion
    reg [CNT_W-1:0] nxt_conv_cnt;
    reg [1:0] conv_res_ff; // Resolution frozen per conversion
    reg [1:0] nxt_conv_res;
    reg sd_entry; // Pulse: conversion done, going to standby
    reg conv_done;
    reg conv_start;

    // Result path
    reg [15:0] nxt_result;
    reg [15:0] res_mask;
    reg [15:0] nxt_tos;
    reg [15:0] nxt_hyst;
    reg [15:0] nxt_rdata;
    reg nxt_alarm;

    // Line drive
    reg release_hold_ff; // Keep SDA released until framing lets go
    wire lock_timeout;
    wire cfg_sd;
    wire cfg_tm;
    wire [1:0] cfg_res;
    wire [CNT_W-1:0] conv_len;
    wire [1:0] start_res; // Resolution of the conversion about to start

    assign cfg_sd = cfg_ff[`TSR_CFG_SD];
    assign cfg_tm = cfg_ff[`TSR_CFG_TM];
    assign cfg_res = {cfg_ff[`TSR_CFG_RES_HI], cfg_ff[`TSR_CFG_RES_LO]};
    // Boot conversion uses the restored image, cfg_ff is still loading then
    assign start_res = (state_ff == ST_BOOT) ?
        {nv_config[`TSR_CFG_RES_HI], nv_config[`TSR_CFG_RES_LO]} : cfg_res;
    // Each step up in resolution doubles the time; no feedback from nxt_ values
    assign conv_len = CONV_BASE_CYC[CNT_W-1:0] << start_res;

    // Watchdog for our own long SDA low
    tsr_lockup #(
        .LIMIT_CYC(LOCKUP_CYC),
        .CNT_W(CNT_W)
    ) u_lockup (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sda_level(sda_level_ff),
        .own_drive(sda_oe_ff),
        .timeout_ff(lock_timeout)
    );

    // Two-flop sampling of the bus pins and SCL edge finding
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            scl_meta_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            scl_level_ff <= 1'b1;
            sda_level_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            scl_rise_ff <= 1'b0;
            scl_fall_ff <= 1'b0;
        end
        else
        begin
            scl_meta_ff <= scl_pin;
            sda_meta_ff <= sda_in;
            scl_level_ff <= scl_meta_ff;
            sda_level_ff <= sda_meta_ff;
            scl_prev_ff <= scl_level_ff;
            scl_rise_ff <= scl_level_ff & ~scl_prev_ff;
            scl_fall_ff <= ~scl_level_ff & scl_prev_ff;
        end
    end

    // Open-drain drive: data is always low, only the enable moves
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            sda_out_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            release_hold_ff <= 1'b0;
            serial_reset_ff <= 1'b0;
        end
        else
        begin
            sda_out_ff <= 1'b0;
            serial_reset_ff <= lock_timeout;
            if (lock_timeout)
            begin
                // Drop the line and wait for framing to stop asking
                release_hold_ff <= 1'b1;
                sda_oe_ff <= 1'b0;
            end
            else if (release_hold_ff)
            begin
                release_hold_ff <= sda_pull_req;
                sda_oe_ff <= 1'b0;
            end
            else
            begin
                sda_oe_ff <= sda_pull_req;
            end
        end
    end

    // Sequencer: boot, convert, standby
    always @*
    begin
        nxt_state = state_ff;
        nxt_conv_cnt = conv_cnt_ff;
        nxt_conv_res = conv_res_ff;
        conv_done = 1'b0;
        conv_start = 1'b0;
        sd_entry = 1'b0;
        case (state_ff)
            ST_BOOT:
            begin
                // Always one conversion first, whatever the setting
                conv_start = 1'b1;
                nxt_state = ST_CONV;
            end
            ST_CONV:
            begin
                if (conv_cnt_ff == {CNT_W{1'b0}})
                begin
                    conv_done = 1'b1;
                    if (cfg_sd)
                    begin
                        // Finish first, then sleep
                        sd_entry = 1'b1;
                        nxt_state = ST_STANDBY;
                    end
                    else
                    begin
                        // Back to back in continuous mode
                        conv_start = 1'b1;
                    end
                end
                else
                begin
                    nxt_conv_cnt = conv_cnt_ff - 1'b1;
                end
            end
            ST_STANDBY:
            begin
                // Wake when shutdown is written back to zero
                if (!cfg_sd)
                begin
                    conv_start = 1'b1;
                    nxt_state = ST_CONV;
                end
            end
            default:
            begin
                nxt_state = ST_BOOT;
            end
        endcase
        if (conv_start)
        begin
            // Freeze resolution so a mid-run write cannot tear it
            nxt_conv_res = start_res;
            nxt_state = ST_CONV;
            nxt_conv_cnt = conv_len - 1'b1;
        end
    end

    // Result packing and resolution masking
    always @*
    begin
        case (conv_res_ff)
            `TSR_RES_9B: res_mask = `TSR_MASK_9B;
            `TSR_RES_10B: res_mask = `TSR_MASK_10B;
            `TSR_RES_11B: res_mask = `TSR_MASK_11B;
            `TSR_RES_12B: res_mask = `TSR_MASK_12B;
            default: res_mask = `TSR_MASK_9B;
        endcase
        nxt_result = temperature_result_ff;
        if (conv_done)
        begin
            // Whole word at once, sign at bit 15, low nibble zero
            nxt_result = adc_temp & res_mask;
        end
    end

    // Register writes from the framing layer
    always @*
    begin
        nxt_cfg = cfg_ff;
        nxt_tos = overtemp_trip_point_ff;
        nxt_hyst = lower_trip_point_ff;
        if (state_ff == ST_BOOT)
        begin
            // Restore the stored settings once after reset
            nxt_cfg = nv_config & `TSR_CFG_WMASK;
        end
        else if (reg_wr_stb)
        begin
            case (reg_ptr)
                `TSR_PTR_CFG: nxt_cfg = reg_wdata[7:0] & `TSR_CFG_WMASK;
                `TSR_PTR_TOS: nxt_tos = reg_wdata & `TSR_TRIP_MASK;
                `TSR_PTR_HYST: nxt_hyst = reg_wdata & `TSR_TRIP_MASK;
                default: nxt_cfg = cfg_ff; // Result is read only
            endcase
        end
    end

    // Register reads, no side effect on the sequencer
    always @*
    begin
        case (reg_ptr)
            `TSR_PTR_TEMP: nxt_rdata = temperature_result_ff;
            `TSR_PTR_CFG: nxt_rdata = {8'h00, cfg_ff};
            `TSR_PTR_TOS: nxt_rdata = overtemp_trip_point_ff;
            `TSR_PTR_HYST: nxt_rdata = lower_trip_point_ff;
            default: nxt_rdata = `TSR_WORD_RST;
        endcase
    end

    // Alarm hold: a new trip beats a clear in the same cycle
    always @*
    begin
        nxt_alarm = alarm_active_ff;
        if (thermo_set)
        begin
            nxt_alarm = 1'b1;
        end
        else if (cfg_tm)
        begin
            // Interrupt mode: any read or shutdown entry clears
            if (reg_rd_stb || sd_entry)
            begin
                nxt_alarm = 1'b0;
            end
        end
        else if (thermo_clr)
        begin
            // Comparator mode: only hysteresis clears, not shutdown
            nxt_alarm = 1'b0;
        end
    end

    // State registers
    always @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state_ff <= ST_BOOT;
            conv_cnt_ff <= {CNT_W{1'b0}};
            conv_res_ff <= `TSR_RES_9B;
            cfg_ff <= `TSR_CFG_RST;
            temperature_result_ff <= `TSR_WORD_RST;
            overtemp_trip_point_ff <= `TSR_TOS_RST;
            lower_trip_point_ff <= `TSR_HYST_RST;
            reg_rdata_ff <= `TSR_WORD_RST;
            reg_rvalid_ff <= 1'b0;
            alarm_active_ff <= 1'b0;
            conv_active_ff <= 1'b0;
            result_stb_ff <= 1'b0;
            resolution_ff <= `TSR_RES_9B;
            standby_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            conv_cnt_ff <= nxt_conv_cnt;
            conv_res_ff <= nxt_conv_res;
            cfg_ff <= nxt_cfg;
            temperature_result_ff <= nxt_result;
            overtemp_trip_point_ff <= nxt_tos;
            lower_trip_point_ff <= nxt_hyst;
            reg_rvalid_ff <= reg_rd_stb;
            if (reg_rd_stb)
            begin
                reg_rdata_ff <= nxt_rdata;
            end
            alarm_active_ff <= nxt_alarm;
            conv_active_ff <= (nxt_state == ST_CONV);
            result_stb_ff <= conv_done;
            resolution_ff <= nxt_conv_res;
            standby_ff <= (nxt_state == ST_STANDBY);
        end
    end
endmodule

// ==== tb/tsr_monitor.sv ====
// Checker on the tsr_top ports: result word, register port, lockup release.
// Assumes one sys_clk domain and a bind into every tsr_top.
`timescale 1ns/1ps
`include "tsr_consts.vh"
module tsr_monitor #(
    parameter LOCKUP_CYC = `TSR_LOCKUP_MIN_MS * `TSR_CLK_KHZ
) (
    input wire sys_clk,
    input wire rst_b,
    input wire sda_out_ff,
    input wire sda_oe_ff,
    input wire sda_level_ff,
    input wire serial_reset_ff,
    input wire reg_rd_stb,
    input wire [`TSR_PTR_W-1:0] reg_ptr,
    input wire [15:0] reg_rdata_ff,
    input wire reg_rvalid_ff,
    input wire conv_active_ff,
    input wire result_stb_ff,
    input wire [15:0] temperature_result_ff,
    input wire standby_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Run length of our own low drive, mirrors the release counter
    reg [`TSR_CNT_W-1:0] low_run_ff;
    wire [`TSR_CNT_W-1:0] nxt_low_run;
    assign nxt_low_run = (sda_oe_ff && !sda_level_ff) ? low_run_ff + 1'b1 : {`TSR_CNT_W{1'b0}};
    // Cleared in reset so a second reset starts a fresh run
    always @(posedge sys_clk)
    begin
        low_run_ff <= rst_b ? nxt_low_run : {`TSR_CNT_W{1'b0}};
    end
    property p_no_high; sda_out_ff == 1'b0; endproperty
    a_no_high: assert property (p_no_high) else $error("data line driven high");
    property p_rvalid; reg_rd_stb ##1 !reg_rd_stb |-> reg_rvalid_ff ##1 !reg_rvalid_ff; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");
    property p_rdata;
        reg_rd_stb && reg_ptr == `TSR_PTR_TEMP |=> reg_rdata_ff == $past(temperature_result_ff);
    endproperty
    a_rdata: assert property (p_rdata) else $error("result read wrong");
    property p_nibble; temperature_result_ff[3:0] == 4'h0; endproperty
    a_nibble: assert property (p_nibble) else $error("result low bits set");
    property p_atomic; !$stable(temperature_result_ff) |-> result_stb_ff; endproperty
    a_atomic: assert property (p_atomic) else $error("result changed without strobe");
    property p_idle; standby_ff |-> !conv_active_ff; endproperty
    a_idle: assert property (p_idle) else $error("converting in standby");
    property p_boot; $rose(rst_b) |-> ##[1:2] conv_active_ff; endproperty
    a_boot: assert property (p_boot) else $error("no conversion after reset");
    property p_own; serial_reset_ff |-> $past(sda_oe_ff); endproperty
    a_own: assert property (p_own) else $error("reset while not driving");
    property p_drop; serial_reset_ff |=> !sda_oe_ff; endproperty
    a_drop: assert property (p_drop) else $error("line not released");
    property p_span;
        serial_reset_ff |-> low_run_ff + 4 >= LOCKUP_CYC && low_run_ff <= LOCKUP_CYC + 4;
    endproperty
    a_span: assert property (p_span) else $error("lockup span wrong");
endmodule
bind tsr_top tsr_monitor #(.LOCKUP_CYC(LOCKUP_CYC)) mon_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff),
    .sda_level_ff(sda_level_ff), .serial_reset_ff(serial_reset_ff), .reg_rd_stb(reg_rd_stb),
    .reg_ptr(reg_ptr), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .conv_active_ff(conv_active_ff), .result_stb_ff(result_stb_ff),
    .temperature_result_ff(temperature_result_ff), .standby_ff(standby_ff)
);

// ==== tb/tsr_bus_master.sv ====
// 2-wire master model: clock within frames, wired data level.
// Assumes pull-ups on both lines; clock idles high between frames.
`timescale 1ns/1ps
module tsr_bus_master (
    input wire frame_en,
    input wire hold_low,
    input wire sda_oe,
    input wire sda_out,
    output reg scl_pin,
    output wire sda_wire
);
    // Half period 100 ns, stands still high outside a frame
    initial scl_pin = 1'b1;
    always
    begin
        #100;
        scl_pin = frame_en ? ~scl_pin : 1'b1;
    end
    // Wired AND; a driven high level from the block reads the same as released here
    assign sda_wire = ~((sda_oe & ~sda_out) | hold_low);
endmodule

// ==== tb/testbench.sv ====
// Bench for tsr_top: behavioural result model compared after each new reading.
// Assumes short counts: 20-cycle base conversion, 50-cycle lockup.
`timescale 1ns/1ps
`include "tsr_consts.vh"
module testbench;
    localparam BASE = 20;
    localparam LOCK = 50;
    reg sys_clk = 1'b0;
    reg rst_b = 1'b0;
    reg rd_stb = 1'b0;
    reg wr_stb = 1'b0;
    reg [1:0] ptr = 2'h0;
    reg [15:0] wdata = 16'h0000;
    reg [7:0] nv_cfg = 8'h02; // Interrupt mode, 9 bits, running
    reg [15:0] adc = 16'h0000;
    reg t_set = 1'b0;
    reg t_clr = 1'b0;
    reg pull_req = 1'b0;
    reg frame_en = 1'b0;
    reg hold_low = 1'b0;
    reg got = 1'b0;
    reg [31:0] seed = 32'h00002757;
    wire scl, sda, sda_out, sda_oe, scl_rise, srst, rvalid, conv, stb, alarm, standby;
    wire scl_fall, scl_lvl;
    wire [15:0] rdata, result, tos, hyst;
    wire [1:0] res;
    integer num_errors = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer t_stb, t0, iv, iv_prev, r, i, k, nr, ns, nf;
    reg [15:0] d, exp_v;
    reg [15:0] tab [0:3];
    // 40 MHz clock and a cycle stamp for intervals
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    tsr_bus_master bus_u (.frame_en(frame_en), .hold_low(hold_low), .sda_oe(sda_oe),
        .sda_out(sda_out), .scl_pin(scl), .sda_wire(sda));
    tsr_top #(.CONV_BASE_CYC(BASE), .LOCKUP_CYC(LOCK)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .scl_pin(scl), .sda_in(sda),
        .sda_out_ff(sda_out), .sda_oe_ff(sda_oe), .sda_pull_req(pull_req),
        .scl_level_ff(scl_lvl), .sda_level_ff(), .scl_rise_ff(scl_rise), .scl_fall_ff(scl_fall),
        .serial_reset_ff(srst), .reg_rd_stb(rd_stb), .reg_wr_stb(wr_stb), .reg_ptr(ptr),
        .reg_wdata(wdata), .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid), .nv_config(nv_cfg),
        .adc_temp(adc), .conv_active_ff(conv), .result_stb_ff(stb),
        .temperature_result_ff(result), .thermo_set(t_set), .thermo_clr(t_clr),
        .overtemp_trip_point_ff(tos), .lower_trip_point_ff(hyst), .resolution_ff(res),
        .alarm_active_ff(alarm), .standby_ff(standby));
    // Xorshift source for readings
    function [15:0] xs();
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            xs = seed[15:0];
        end
    endfunction
    // Model of the stored word: keep 9 to 12 top bits
    function [15:0] pack(input [15:0] a, input [1:0] rs);
        reg signed [15:0] m;
        begin
            m = 16'hff80;
            m = m >>> rs;
            pack = a & m;
        end
    endfunction
    task chk(input [15:0] got_v, input [15:0] exp_w);
        begin
            samples_checked = samples_checked + 1;
            if (got_v !== exp_w)
            begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t got %h exp %h", $time, got_v, exp_w);
            end
        end
    endtask
    // Strobes rise on a falling edge and drop one cycle later
    task rdreg(input [1:0] p, output [15:0] v);
        begin
            @(negedge sys_clk);
            rd_stb = 1'b1;
            ptr = p;
            @(negedge sys_clk);
            rd_stb = 1'b0;
            chk({15'h0000, rvalid}, 16'h0001);
            v = rdata;
        end
    endtask
    task wrreg(input [1:0] p, input [15:0] v);
        begin
            @(negedge sys_clk);
            wr_stb = 1'b1;
            ptr = p;
            wdata = v;
            @(negedge sys_clk);
            wr_stb = 1'b0;
        end
    endtask
    task kick(input sel);
        begin
            @(negedge sys_clk);
            if (sel)
                t_set = 1'b1;
            else
                t_clr = 1'b1;
            @(negedge sys_clk);
            t_set = 1'b0;
            t_clr = 1'b0;
        end
    endtask
    // Bounded wait for the next result strobe
    task wait_stb;
        integer w;
        begin
            w = 0;
            @(negedge sys_clk);
            while (stb !== 1'b1 && w < 400)
            begin
                @(negedge sys_clk);
                w = w + 1;
            end
            got = (stb === 1'b1);
            t_stb = cyc;
        end
    endtask
    task summarize;
        begin
            $display("checked %0d mismatches %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Watchdog well past the expected few thousand cycles
    initial
    begin
        #400000;
        num_errors = num_errors + 1;
        summarize;
    end
    initial
    begin
        tab[0] = 16'h7d00;
        tab[1] = 16'hff80;
        tab[2] = 16'hc900;
        tab[3] = 16'hf5e0;
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        wrreg(2'h0, 16'hffff);
        rdreg(2'h0, d);
        chk(d, 16'h0000);
        rdreg(2'h2, d);
        chk(d, 16'h5000);
        rdreg(2'h3, d);
        chk(d, 16'h4b00);
        chk({14'h0000, res}, 16'h0000);
        // Each resolution: mask and doubling of the conversion time
        for (r = 0; r < 4; r = r + 1)
        begin
            wrreg(2'h1, {9'h000, r[1:0], 5'h02});
            wait_stb;
            t0 = t_stb;
            adc = xs();
            wait_stb;
            iv = t_stb - t0;
            exp_v = pack(adc, r[1:0]);
            chk(result, exp_v);
            chk({14'h0000, res}, r[15:0]);
            if (r > 0)
                chk(iv - iv_prev, BASE << (r - 1));
            iv_prev = iv;
        end
        // Table values, with a read in mid-conversion
        for (i = 0; i < 6; i = i + 1)
        begin
            t0 = t_stb;
            adc = (i < 4) ? tab[i] : xs();
            rdreg(2'h0, d);
            chk(d, exp_v);
            wait_stb;
            exp_v = pack(adc, 2'h3);
            chk(result, exp_v);
            chk(t_stb - t0, iv_prev);
        end
        kick(1'b1);
        chk({15'h0000, alarm}, 16'h0001);
        rdreg(2'h1, d);
        chk(d, 16'h0062);
        chk({15'h0000, alarm}, 16'h0000);
        wrreg(2'h1, 16'h0060);
        kick(1'b1);
        rdreg(2'h2, d);
        chk({15'h0000, alarm}, 16'h0001);
        kick(1'b0);
        chk({15'h0000, alarm}, 16'h0000);
        // Trip words keep only the top twelve bits, read back and on the ports
        d = xs();
        wrreg(2'h2, d);
        wrreg(2'h3, ~d);
        rdreg(2'h2, exp_v);
        chk(exp_v, d & 16'hfff0);
        rdreg(2'h3, exp_v);
        chk(exp_v, ~d & 16'hfff0);
        chk(tos, d & 16'hfff0);
        chk(hyst, ~d & 16'hfff0);
        // Shutdown in mid-conversion with the alarm raised
        kick(1'b1);
        wrreg(2'h1, 16'h0063);
        adc = xs();
        wait_stb;
        exp_v = pack(adc, 2'h3);
        chk(result, exp_v);
        repeat (2) @(negedge sys_clk);
        chk({15'h0000, standby}, 16'h0001);
        chk({15'h0000, alarm}, 16'h0000);
        wait_stb;
        chk({15'h0000, got}, 16'h0000);
        rdreg(2'h0, d);
        chk(d, exp_v);
        wrreg(2'h1, 16'h0062);
        adc = xs();
        wait_stb;
        chk({15'h0000, got}, 16'h0001);
        chk(result, pack(adc, 2'h3));
        // Power-up with shutdown stored
        nv_cfg = 8'h21;
        rst_b = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        adc = xs();
        wait_stb;
        chk(result, pack(adc, 2'h1));
        chk({14'h0000, res}, 16'h0001);
        wait_stb;
        chk({15'h0000, got}, 16'h0000);
        chk({15'h0000, standby}, 16'h0001);
        // Own low drive runs into the release time
        frame_en = 1'b1;
        pull_req = 1'b1;
        k = 0;
        while (srst !== 1'b1 && k < 200)
        begin
            @(negedge sys_clk);
            k = k + 1;
        end
        chk({15'h0000, k >= LOCK && k <= LOCK + 6}, 16'h0001);
        @(negedge sys_clk);
        chk({15'h0000, sda_oe}, 16'h0000);
        pull_req = 1'b0;
        hold_low = 1'b1;
        nr = 0;
        ns = 0;
        nf = 0;
        for (k = 0; k < 160; k = k + 1)
        begin
            @(negedge sys_clk);
            nr = nr + scl_rise;
            nf = nf + scl_fall;
            ns = ns + srst;
        end
        chk(ns[15:0], 16'h0000);
        chk({15'h0000, nr >= 19 && nr <= 21}, 16'h0001);
        chk({15'h0000, nf >= 19 && nf <= 21}, 16'h0001);
        hold_low = 1'b0;
        frame_en = 1'b0;
        // Clock parks high outside a frame; synced level follows
        repeat (8) @(negedge sys_clk);
        chk({15'h0000, scl_lvl}, 16'h0001);
        summarize;
    end
endmodule
